// ===== csl_top.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module csl_top
	import csl_pkg::*;
#(
	parameter int BIT_CYC_P = BIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd_pin,
	output logic txd_pin,
	input wire logic power_ok_signal,
	input wire logic cpu_halted,
	output logic tx_int_req,
	output logic [7:0] tx_int_vector,
	output logic [4:0] tx_int_level
);
	// pin synchronisers: {halted, power ok, serial in}
	logic [2:0] s1, s2, s3, stab;
	logic pok_q;
	// receive side state
	logic rx_done, ovr, frm, brk;
	logic [7:0] rx_buf;
	// transmit side state
	logic tie, loopback_maintenance, xbrk, brk_on;
	logic [7:0] hold;
	logic hold_full;
	// engine hookup
	logic rx_valid, rx_framing_flag, rx_brk;
	logic [7:0] rx_data;
	logic tx_busy, tx_raw;
	logic [31:0] receive_control_status_val, receive_data_buffer_val, transmit_control_status_val, rd_mux;

	// second and third stage must agree before a pin change counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= SYNC_RST;
			s2 <= SYNC_RST;
			s3 <= SYNC_RST;
			stab <= SYNC_RST;
			pok_q <= 1'b1;
		end else begin
			s1 <= {cpu_halted, power_ok_signal, rxd_pin};
			s2 <= s1;
			s3 <= s2;
			stab <= (s2 & s3) | (stab & (s2 ^ s3));
			pok_q <= stab[1];
		end
	end

	// power ok falling while halted acts as a soft reset
	wire soft_clr = pok_q && !stab[1] && stab[2];

	// bus decode; reads are sampled in the setup cycle
	wire setup = psel && !penable;
	wire acc = psel && penable;
	wire hit_receive_control_status = paddr == RECEIVE_CONTROL_STATUS_OFF;
	wire hit_receive_data_buffer = paddr == RECEIVE_DATA_BUFFER_OFF;
	wire hit_transmit_control_status = paddr == TRANSMIT_CONTROL_STATUS_OFF;
	wire hit_transmit_data_buffer = paddr == TRANSMIT_DATA_BUFFER_OFF;
	wire hit = hit_receive_control_status || hit_receive_data_buffer || hit_transmit_control_status || hit_transmit_data_buffer;
	wire wr_transmit_control_status = acc && pwrite && hit_transmit_control_status;
	wire wr_transmit_data_buffer = acc && pwrite && hit_transmit_data_buffer;
	// side effect on the same edge as the data capture, so a
	// character landing between setup and access is never lost
	wire rd_receive_data_buffer = setup && !pwrite && hit_receive_data_buffer;
	wire tx_rdy = !hold_full;
	wire tx_go = hold_full && !tx_busy;
	// loopback: the external input is ignored as if held at mark
	wire rx_in = loopback_maintenance ? txd_pin : stab[0];

	assign pready = 1'b1;
	assign pslverr = acc && !hit;
	assign tx_int_req = tie && tx_rdy;
	assign tx_int_vector = TX_VECTOR;
	assign tx_int_level = TX_IPL;

	// read images; everything not placed reads zero
	always_comb begin
		receive_control_status_val = 32'h0000_0000;
		receive_control_status_val[RECEIVE_CONTROL_STATUS_DONE] = rx_done;
		receive_data_buffer_val = 32'h0000_0000;
		receive_data_buffer_val[7:0] = rx_buf;
		receive_data_buffer_val[RECEIVE_DATA_BUFFER_ERR] = ovr || frm;
		receive_data_buffer_val[RECEIVE_DATA_BUFFER_OVR] = ovr;
		receive_data_buffer_val[RECEIVE_DATA_BUFFER_FRM] = frm;
		receive_data_buffer_val[RECEIVE_DATA_BUFFER_BRK] = brk;
		transmit_control_status_val = 32'h0000_0000;
		transmit_control_status_val[TRANSMIT_CONTROL_STATUS_RDY] = tx_rdy;
		transmit_control_status_val[TRANSMIT_CONTROL_STATUS_IE] = tie;
		transmit_control_status_val[TRANSMIT_CONTROL_STATUS_LOOPBACK_MAINTENANCE] = loopback_maintenance;
		transmit_control_status_val[TRANSMIT_CONTROL_STATUS_XBRK] = xbrk;
	end

	// transmit data buffer is write only and reads zero
	assign rd_mux = hit_receive_control_status ? receive_control_status_val : hit_receive_data_buffer ? receive_data_buffer_val : hit_transmit_control_status ? transmit_control_status_val : 32'h0000_0000;

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// receive buffer and flags; a new character beats a read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_done <= 1'b0;
			ovr <= 1'b0;
			frm <= 1'b0;
			brk <= 1'b0;
			rx_buf <= 8'h00;
		end else if (soft_clr) begin
			rx_done <= 1'b0;
			ovr <= 1'b0;
			frm <= 1'b0;
			brk <= 1'b0;
		end else if (rx_valid) begin
			rx_buf <= rx_data;
			rx_done <= 1'b1;
			ovr <= rx_done && !rd_receive_data_buffer;
			frm <= rx_framing_flag;
			brk <= rx_brk;
		end else if (rd_receive_data_buffer) begin
			rx_done <= 1'b0;
			ovr <= 1'b0;
			frm <= 1'b0;
			brk <= 1'b0;
		end
	end

	// transmit control bits; only the low byte's defined bits store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tie <= 1'b0;
			loopback_maintenance <= 1'b0;
			xbrk <= 1'b0;
		end else if (soft_clr) begin
			tie <= 1'b0;
			loopback_maintenance <= 1'b0;
			xbrk <= 1'b0;
		end else if (wr_transmit_control_status) begin
			tie <= pwdata[TRANSMIT_CONTROL_STATUS_IE];
			loopback_maintenance <= pwdata[TRANSMIT_CONTROL_STATUS_LOOPBACK_MAINTENANCE];
			xbrk <= pwdata[TRANSMIT_CONTROL_STATUS_XBRK];
		end
	end

	// holding buffer; a write while full replaces the waiting byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold <= 8'h00;
			hold_full <= 1'b0;
		end else if (soft_clr) begin
			hold_full <= 1'b0;
		end else if (wr_transmit_data_buffer) begin
			hold <= pwdata[7:0];
			hold_full <= 1'b1;
		end else if (tx_go) begin
			hold_full <= 1'b0;
		end
	end

	// break waits for the frame in flight, then the line is forced
	// low while the engine keeps shifting dummy characters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_on <= 1'b0;
			txd_pin <= 1'b1;
		end else begin
			brk_on <= xbrk && (brk_on || !tx_busy);
			txd_pin <= tx_raw && !brk_on;
		end
	end

	csl_rx #(
		.BIT_CYC_P(BIT_CYC_P)
	) csl_rx_inst (
		.pclk(pclk),
		.presetn(presetn),
		.clr(soft_clr),
		.rx_in(rx_in),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_framing_flag(rx_framing_flag),
		.rx_brk(rx_brk)
	);

	csl_tx #(
		.BIT_CYC_P(BIT_CYC_P)
	) csl_tx_inst (
		.pclk(pclk),
		.presetn(presetn),
		.clr(soft_clr),
		.start(tx_go),
		.data(hold),
		.busy(tx_busy),
		.txd_raw(tx_raw)
	);

	AST_RDY_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_transmit_data_buffer && !soft_clr) |=> (!transmit_control_status_val[TRANSMIT_CONTROL_STATUS_RDY] && hold_full))
		else $error("ready still set after data load");
	AST_IRQ_READY: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tx_rdy) && tie |-> tx_int_req)
		else $error("enabled ready gave no request");
	AST_ERR_SUM: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_receive_data_buffer) |=> (prdata[RECEIVE_DATA_BUFFER_ERR] == (prdata[RECEIVE_DATA_BUFFER_OVR] || prdata[RECEIVE_DATA_BUFFER_FRM])))
		else $error("summary bit disagrees with error bits");
	AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_receive_data_buffer && !rx_valid) |=> !(ovr || frm || brk || rx_done))
		else $error("read left receive flags set");
	AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_valid && rx_done && !rd_receive_data_buffer && !soft_clr) |=> (ovr && rx_buf == $past(rx_data)))
		else $error("overwrite of unread character not flagged");
	AST_BREAK_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		brk_on |=> !txd_pin)
		else $error("line not at space during break");
	AST_LOOPBACK: assert property (@(posedge pclk) disable iff (!presetn)
		loopback_maintenance |-> (rx_in == txd_pin))
		else $error("receiver not fed from output in maintenance");
	AST_POWER_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		soft_clr |=> (tx_rdy && !tie && !loopback_maintenance && !xbrk && !rx_done))
		else $error("power clear left control bits");
	AST_RO_BUFFER: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit_receive_data_buffer && !rx_valid) |=> $stable(rx_buf))
		else $error("write altered receive buffer");

	// register images, flag lifetimes and line levels
	AST_RDY_RISE: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_go && !wr_transmit_data_buffer && !soft_clr) |=> tx_rdy)
		else $error("ready not restored when engine took the byte");
	AST_ENGINE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_go && !soft_clr) |=> tx_busy)
		else $error("loaded character not started");
	AST_WRITE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_transmit_data_buffer && !soft_clr) |=> (hold == $past(pwdata[7:0])))
		else $error("transmit data write not captured");
	AST_RECEIVE_DATA_BUFFER_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_receive_data_buffer) |=> (prdata[31:16] == 16'h0000 && !prdata[12] && prdata[10:8] == 3'h0))
		else $error("unused receive data bits not zero");
	AST_TRANSMIT_CONTROL_STATUS_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_transmit_control_status) |=> (prdata[31:8] == 24'h00_0000 && prdata[5:3] == 3'h0 && !prdata[1]))
		else $error("unused transmit control bits not zero");
	AST_RECEIVE_CONTROL_STATUS_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_receive_control_status) |=> (prdata[31:8] == 24'h00_0000 && prdata[6:0] == 7'h00))
		else $error("unused receive control bits not zero");
	AST_TRANSMIT_DATA_BUFFER_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_transmit_data_buffer) |=> (prdata == 32'h0000_0000))
		else $error("write only buffer returned data");
	AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_valid && !soft_clr) |=> rx_done)
		else $error("done not set by new character");
	AST_FRAME_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_valid && !soft_clr) |=> (frm == $past(rx_framing_flag) && brk == $past(rx_brk)))
		else $error("error flags not updated by new character");
	AST_FLAGS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(!rx_valid && !rd_receive_data_buffer && !soft_clr) |=> $stable({ovr, frm, brk}))
		else $error("error flags changed between characters");
	AST_BUF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!rx_valid |=> $stable(rx_buf))
		else $error("receive buffer changed without a character");
	AST_OVR_CLEAN: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_valid && !rx_done && !soft_clr) |=> !ovr)
		else $error("overrun raised with buffer already read");
	AST_SOFT_RX_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		soft_clr |=> !(ovr || frm || brk))
		else $error("power clear left receive flags");
	AST_CTRL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(!wr_transmit_control_status && !soft_clr) |=> $stable({tie, loopback_maintenance, xbrk}))
		else $error("control bits changed without a write");
	AST_BREAK_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		(xbrk && !brk_on && tx_busy) |=> !brk_on)
		else $error("break cut into the character in flight");
	AST_BREAK_END: assert property (@(posedge pclk) disable iff (!presetn)
		!xbrk |=> !brk_on)
		else $error("break outlived its control bit");
	AST_BREAK_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
		brk_on |-> $past(xbrk))
		else $error("break active without its control bit");
	AST_RUN_IN_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
		(brk_on && wr_transmit_data_buffer && !soft_clr) |=> !tx_rdy)
		else $error("ready not updated during break");
	AST_IDLE_MARK: assert property (@(posedge pclk) disable iff (!presetn)
		(!brk_on && !tx_busy) |=> txd_pin)
		else $error("idle line not at mark");
	AST_IRQ_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		!tie |-> !tx_int_req)
		else $error("request raised with enable clear");
	AST_IRQ_ID: assert property (@(posedge pclk) disable iff (!presetn)
		tx_int_req |-> (tx_int_vector == TX_VECTOR && tx_int_level == TX_IPL))
		else $error("request carries wrong vector or level");
	AST_LOOP_MARK: assert property (@(posedge pclk) disable iff (!presetn)
		(loopback_maintenance && !stab[0] && txd_pin) |-> rx_in)
		else $error("outside space reached receiver in maintenance");
endmodule // csl_top

// ===== csl_pkg.sv
// Operation
// - receive buffer low byte holds last character
// - overrun set when unread character overwritten
// - framing set when stop bit missing
// - reading receive buffer or power clear clears flags
// - bit 15 is overrun or framing, no interrupt
// - error flags update only with next character
// - break flag after 20 space bit times
// - unused bits read zero, writes ignored
// - transmit ready drops on load, rises when free
// - transmit ready set by power clears
// - enable and ready request level 14 vector FC
// - maintenance loops output to input, input marked
// - break holds line space after current character
// - during break transmitter still runs normally
// - power clears zero enable, maintenance, break
// - receive done set on character, cleared by read
// - eight data bits, no parity, one stop
// - transmit data write loads next character
package csl_pkg;
	// register byte offsets
	localparam logic [7:0] RECEIVE_CONTROL_STATUS_OFF = 8'h00;
	localparam logic [7:0] RECEIVE_DATA_BUFFER_OFF = 8'h04;
	localparam logic [7:0] TRANSMIT_CONTROL_STATUS_OFF = 8'h08;
	localparam logic [7:0] TRANSMIT_DATA_BUFFER_OFF = 8'h0C;
	// field positions
	localparam int RECEIVE_CONTROL_STATUS_DONE = 7;
	localparam int RECEIVE_DATA_BUFFER_ERR = 15;
	localparam int RECEIVE_DATA_BUFFER_OVR = 14;
	localparam int RECEIVE_DATA_BUFFER_FRM = 13;
	localparam int RECEIVE_DATA_BUFFER_BRK = 11;
	localparam int TRANSMIT_CONTROL_STATUS_RDY = 7;
	localparam int TRANSMIT_CONTROL_STATUS_IE = 6;
	localparam int TRANSMIT_CONTROL_STATUS_LOOPBACK_MAINTENANCE = 2;
	localparam int TRANSMIT_CONTROL_STATUS_XBRK = 0;
	// reset values
	localparam logic [2:0] SYNC_RST = 3'h3;
	localparam logic [9:0] TX_IDLE = 10'h3FF;
	// line timing
	localparam int CLK_HZ = 10000000;
	localparam int BAUD_HZ = 9600;
	localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
	localparam int BRK_BITS = 20;
	localparam int DATA_BITS = 8;
	// transmit interrupt identity
	localparam logic [7:0] TX_VECTOR = 8'hFC;
	localparam logic [4:0] TX_IPL = 5'h14;
endpackage

// ===== csl_rx.sv
`timescale 1ns/10ps
module csl_rx
	import csl_pkg::*;
#(
	parameter int BIT_CYC_P = BIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic rx_in,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_framing_flag,
	output logic rx_brk
);
	typedef enum logic [1:0] {
		CSL_RX_IDLE = 2'b00,
		CSL_RX_START = 2'b01,
		CSL_RX_DATA = 2'b10,
		CSL_RX_STOP = 2'b11
	} csl_rx_state_e;
	csl_rx_state_e st;
	logic [15:0] cnt;
	logic [2:0] bitn;
	logic [4:0] spc;
	logic armed;
	logic [7:0] shf;

	// sample points: mid start bit, then one bit time apart
	wire tick = cnt == 16'(BIT_CYC_P - 1);
	wire half = cnt == 16'(BIT_CYC_P / 2 - 1);
	wire restart = (st == CSL_RX_IDLE) || tick || (st == CSL_RX_START && half);
	wire smp = (st == CSL_RX_START) ? half : ((st != CSL_RX_IDLE) && tick);
	// consecutive space bits, saturating
	wire [4:0] next_spc = rx_in ? 5'h00 : ((spc == 5'(BRK_BITS)) ? spc : spc + 5'h01);
	wire brk_now = armed && (next_spc == 5'(BRK_BITS));

	// receive engine; a frame that ends in space is followed at once
	// by another, so a held space reaches the break count at 2 frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= CSL_RX_IDLE;
			cnt <= 16'h0000;
			bitn <= 3'h0;
			spc <= 5'h00;
			armed <= 1'b1;
			shf <= 8'h00;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_framing_flag <= 1'b0;
			rx_brk <= 1'b0;
		end else if (clr) begin
			st <= CSL_RX_IDLE;
			cnt <= 16'h0000;
			spc <= 5'h00;
			armed <= 1'b1;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			cnt <= restart ? 16'h0000 : cnt + 16'h0001;
			if (smp) begin
				spc <= next_spc;
			end
			if (rx_in) begin
				armed <= 1'b1;
			end
			unique case (st)
				CSL_RX_IDLE: begin
					if (!rx_in) begin
						st <= CSL_RX_START;
					end
				end
				CSL_RX_START: begin
					bitn <= 3'h0;
					if (half) begin
						st <= rx_in ? CSL_RX_IDLE : CSL_RX_DATA;
					end
				end
				CSL_RX_DATA: begin
					if (tick) begin
						shf <= {rx_in, shf[7:1]};
						bitn <= bitn + 3'h1;
						if (bitn == 3'(DATA_BITS - 1)) begin
							st <= CSL_RX_STOP;
						end
					end
				end
				CSL_RX_STOP: begin
					if (tick) begin
						rx_valid <= 1'b1;
						rx_data <= shf;
						rx_framing_flag <= !rx_in;
						rx_brk <= brk_now;
						if (brk_now) begin
							armed <= 1'b0;
						end
						st <= CSL_RX_IDLE;
					end
				end
			endcase
		end
	end

	AST_STOP_FRAMING: assert property (@(posedge pclk) disable iff (!presetn)
		(st == CSL_RX_STOP && tick && !rx_in && !clr) |=> (rx_valid && rx_framing_flag))
		else $error("missing stop bit not flagged");
endmodule // csl_rx

// ===== csl_tx.sv
`timescale 1ns/10ps
module csl_tx
	import csl_pkg::*;
#(
	parameter int BIT_CYC_P = BIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic start,
	input wire logic [7:0] data,
	output logic busy,
	output logic txd_raw
);
	logic [9:0] shf;
	logic [3:0] left;
	logic [15:0] cnt;

	wire tick = cnt == 16'(BIT_CYC_P - 1);
	assign busy = left != 4'h0;
	assign txd_raw = shf[0];

	// stop, data lsb first, start; ones shift in behind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shf <= TX_IDLE;
			left <= 4'h0;
			cnt <= 16'h0000;
		end else if (clr) begin
			shf <= TX_IDLE;
			left <= 4'h0;
			cnt <= 16'h0000;
		end else if (start && !busy) begin
			shf <= {1'b1, data, 1'b0};
			left <= 4'(DATA_BITS + 2);
			cnt <= 16'h0000;
		end else if (busy) begin
			cnt <= tick ? 16'h0000 : cnt + 16'h0001;
			if (tick) begin
				shf <= {1'b1, shf[9:1]};
				left <= left - 4'h1;
			end
		end
	end

	AST_START_BIT: assert property (@(posedge pclk) disable iff (!presetn)
		(start && !busy && !clr) |=> (!txd_raw && busy))
		else $error("frame did not open with a space start bit");
endmodule // csl_tx

// ===== csl_term.sv
`timescale 1ns/10ps
module csl_term #(
	parameter int BIT_CYC_P = 16
) (
	input wire logic pclk,
	input wire logic line_in,
	output logic line_out,
	output logic got_stb,
	output logic [8:0] got_word
);
	logic [8:0] w;

	// terminal sender, one bit per BIT_CYC_P clocks, idles at mark
	initial begin
		line_out = 1'b1;
		got_stb = 1'b0;
		got_word = 9'h000;
	end

	task automatic send(input logic [7:0] b, input logic stop);
		@(posedge pclk);
		line_out <= 1'b0;
		repeat (BIT_CYC_P) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			line_out <= b[i];
			repeat (BIT_CYC_P) @(posedge pclk);
		end
		line_out <= stop;
		repeat (BIT_CYC_P) @(posedge pclk);
		line_out <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	// hold the line at space, then return to mark
	task automatic space(input int bits);
		@(posedge pclk);
		line_out <= 1'b0;
		repeat (bits * BIT_CYC_P) @(posedge pclk);
		line_out <= 1'b1;
	endtask

	// receiver samples mid bit; a fresh start needs the line back at mark first
	initial forever begin
		wait (line_in === 1'b1);
		@(negedge line_in);
		repeat (BIT_CYC_P / 2) @(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYC_P) @(posedge pclk);
			w[i] = line_in;
		end
		got_word <= {w[8], w[7:0]};
		got_stb <= 1'b1;
		@(posedge pclk);
		got_stb <= 1'b0;
	end
endmodule // csl_term

// ===== csl_top_tb.sv
`timescale 1ns/10ps
module csl_top_tb;
	localparam int BC = 16;
	localparam int FR = 10 * BC + 20;
	logic pclk, presetn, psel, penable, pwrite, power_ok_signal, cpu_halted;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic pready, pslverr, rxd_pin, txd_pin, tx_int_req, got_stb;
	logic [7:0] tx_int_vector;
	logic [4:0] tx_int_level;
	logic [8:0] got_word;
	logic [32:0] rd_q[$];
	logic [8:0] tx_q[$];
	int miscompares, tests_run;

	csl_top #(.BIT_CYC_P(BC)) csl_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .power_ok_signal(power_ok_signal),
		.cpu_halted(cpu_halted), .tx_int_req(tx_int_req), .tx_int_vector(tx_int_vector),
		.tx_int_level(tx_int_level));
	csl_term #(.BIT_CYC_P(BC)) csl_term_inst (.pclk(pclk), .line_in(txd_pin), .line_out(rxd_pin),
		.got_stb(got_stb), .got_word(got_word));

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one apb transfer; the read expectation is queued at setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			rd_q.push_back({a > 8'h0C, d});
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, e);
	endtask

	// read answers taken at the completing access edge
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			check({pslverr, prdata}, rd_q.pop_front());
	end

	// characters seen by the terminal, oldest note first
	always @(posedge pclk) begin
		if (got_stb === 1'b1)
			check(33'(got_word), 33'(tx_q.pop_front()));
	end

	// watchdog sized well past the whole sequence
	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		rnd = 32'h7;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = rnd[0];
		paddr = rnd[7:0];
		pwdata = rnd;
		power_ok_signal = 1'b1;
		cpu_halted = 1'b0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h08, 32'h80);
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h0);
		check({tx_int_req, tx_int_vector, tx_int_level}, {1'b0, 8'hFC, 5'h14});
		wr(8'h08, 32'hFFFFFF3A);
		rd(8'h08, 32'h80);
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
		wr(8'h00, 32'hFFFFFFFF);
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h0);
		// interrupt request follows enable and ready
		wr(8'h08, 32'h40);
		repeat (2) @(posedge pclk);
		check(33'(tx_int_req), 33'h1);
		rd(8'h08, 32'hC0);
		wr(8'h08, 32'h0);
		repeat (2) @(posedge pclk);
		check(33'(tx_int_req), 33'h0);
		// random characters both ways
		for (int i = 0; i < 3; i++) begin
			rnd = xs(rnd);
			tx_q.push_back({1'b1, rnd[7:0]});
			wr(8'h0C, rnd);
			repeat (FR) @(posedge pclk);
			csl_term_inst.send(rnd[15:8], 1'b1);
			repeat (8) @(posedge pclk);
			rd(8'h00, 32'h80);
			rd(8'h04, {24'h0, rnd[15:8]});
			rd(8'h00, 32'h0);
		end
		// second write waits in the holding buffer
		tx_q.push_back(9'h111);
		tx_q.push_back(9'h122);
		wr(8'h0C, 32'h11);
		wr(8'h0C, 32'h22);
		rd(8'h08, 32'h0);
		repeat (2 * FR) @(posedge pclk);
		rd(8'h08, 32'h80);
		// overrun, then framing, then flags cleared by the read
		csl_term_inst.send(8'hA5, 1'b1);
		csl_term_inst.send(8'h3C, 1'b1);
		repeat (8) @(posedge pclk);
		rd(8'h04, 32'hC03C);
		csl_term_inst.send(8'h96, 1'b0);
		repeat (8) @(posedge pclk);
		rd(8'h00, 32'h80);
		rd(8'h04, 32'hA096);
		rd(8'h04, 32'h0096);
		// long space: two framed zeros, the second marks the break
		csl_term_inst.space(22);
		repeat (8) @(posedge pclk);
		rd(8'h04, 32'hE800);
		rd(8'h04, 32'h0);
		// the held space runs into a third frame: two more space bits, then mark
		repeat (FR) @(posedge pclk);
		rd(8'h04, 32'hFC);
		// break after the current character, dummy character timed under it
		tx_q.push_back(9'h15A);
		tx_q.push_back(9'h000);
		wr(8'h0C, 32'h5A);
		wr(8'h08, 32'h01);
		wr(8'h0C, 32'h55);
		rd(8'h08, 32'h01);
		repeat (3 * FR) @(posedge pclk);
		rd(8'h08, 32'h81);
		wr(8'h08, 32'h0);
		repeat (FR) @(posedge pclk);
		// loopback ignores a space on the outside pin
		wr(8'h08, 32'h04);
		tx_q.push_back(9'h1C3);
		fork
			csl_term_inst.space(12);
			wr(8'h0C, 32'hC3);
		join
		repeat (FR) @(posedge pclk);
		rd(8'h04, 32'hC3);
		wr(8'h08, 32'h0);
		// power-ok falling while halted clears state
		csl_term_inst.send(8'h77, 1'b1);
		repeat (8) @(posedge pclk);
		wr(8'h08, 32'h44);
		// random activity on one pin alone must clear nothing
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			power_ok_signal <= rnd[i];
		end
		@(posedge pclk);
		power_ok_signal <= 1'b1;
		repeat (8) @(posedge pclk);
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			cpu_halted <= rnd[i + 16];
		end
		@(posedge pclk);
		cpu_halted <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(8'h08, 32'hC4);
		cpu_halted <= 1'b1;
		@(posedge pclk);
		power_ok_signal <= 1'b0;
		repeat (12) @(posedge pclk);
		rd(8'h08, 32'h80);
		rd(8'h00, 32'h0);
		power_ok_signal <= 1'b1;
		cpu_halted <= 1'b0;
		repeat (FR) @(posedge pclk);
		check(33'(tx_q.size()), 33'h0);
		tally_and_finish();
	end
endmodule // csl_top_tb
